/* File: src/msf_pkg.sv */
// package: offsets, field positions, reset values and carriers for the status and flag bytes
package msf_pkg;

	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned DATA_W   = 8;
	localparam int unsigned CHAN_N   = 4;

	// byte offsets in the lower page
	localparam logic [7:0] OFF_REVISION   = 8'h01;
	localparam logic [7:0] OFF_STATUS     = 8'h02;
	localparam logic [7:0] OFF_LOS_FLAGS  = 8'h03;
	localparam logic [7:0] OFF_FAULT      = 8'h04;
	localparam logic [7:0] OFF_LOCK_LOSS  = 8'h05;

	// status byte fields
	localparam int unsigned STS_FLAT_MEM_BIT   = 2;
	localparam int unsigned STS_INT_PIN_BIT    = 1;
	localparam int unsigned STS_NOT_READY_BIT  = 0;

	// nibble positions inside the flag bytes (channel 1 at the low bit)
	localparam int unsigned HI_NIBBLE_LSB = 4;
	localparam int unsigned LO_NIBBLE_LSB = 0;

	// values after reset and for unmapped reads
	localparam logic [7:0] FLAGS_RESET   = 8'h00;
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;
	localparam logic [7:0] RD_DATA_RESET = 8'h00;

	// read answer lands one cycle after the strobe
	localparam int unsigned RD_LATENCY_CYCLES = 1;

	// per-channel live condition inputs, bit 0 is channel 1
	typedef struct packed {
		logic [3:0] rx_los;
		logic [3:0] tx_eq_fault;
		logic [3:0] tx_laser_fault;
		logic [3:0] tx_unlock;
		logic [3:0] rx_unlock;
	} msf_cond_s;

	// byte read from the serial protocol engine
	typedef struct packed {
		logic       strobe;
		logic [7:0] addr;
	} msf_rd_req_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} msf_rd_rsp_s;

endpackage

/* File: src/msf_flag_latch.sv */
// one byte of sticky flags: set by live conditions, cleared by a read or the module reset pin
`timescale 1ns/1ps

module msf_flag_latch #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] cond,
	input  wire logic [WIDTH-1:0] supported,
	input  wire logic             read_clear,
	input  wire logic             pin_clear,
	output logic      [WIDTH-1:0] flags
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic bit_reg;
			logic bit_next;
			logic set_w;

			// unsupported bits never set, so they read zero and stay off the interrupt
			assign set_w = cond[i] & supported[i];
			// pin clear dominates; a set in the read-clear cycle survives the clear
			assign bit_next = pin_clear ? 1'b0 : (set_w | (bit_reg & ~read_clear));

			always_ff @(posedge clk or posedge reset)
			begin
				if (reset)
					bit_reg <= msf_pkg::FLAGS_RESET[0];
				else
					bit_reg <= bit_next;
			end

			assign flags[i] = bit_reg;
		end
	endgenerate

endmodule // msf_flag_latch

/* File: src/msf_status_flags.sv */
// status bytes and latched channel flag bytes of the module management lower page
//
// Summary of operation
// - byte 1 returns fixed revision compliance code
// - byte 2 bit 2 reports flat or paged memory
// - byte 2 bit 1 mirrors interrupt pin level
// - byte 2 bit 0 high until monitors ready
// - bytes 3 to 5 form latched flag field
// - flag bits are zero after reset, normally
// - defined conditions set their flag bits
// - flags stay set until a covering read
// - module reset pin clears every latched flag
// - byte 3 low nibble holds rx signal loss
// - byte 3 high nibble tx loss, unsupported
// - byte 4 high nibble holds equalizer faults
// - byte 4 low nibble holds laser faults
// - byte 5 high nibble tx recovery unlock
// - byte 5 low nibble rx recovery unlock
// - bytes reached individually over the serial bus
`timescale 1ns/1ps

module msf_status_flags #(
	parameter logic [7:0] REVISION_CODE = 8'h07,
	parameter logic       FLAT_MEM      = 1'b0,
	parameter logic       EQ_SUPPORTED  = 1'b1
) (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  module_reset_n,
	input  wire logic                  monitor_ready,
	input  wire msf_pkg::msf_cond_s    cond,
	input  wire msf_pkg::msf_rd_req_s  rd_req,
	output msf_pkg::msf_rd_rsp_s       rd_rsp,
	output logic                       interrupt_out_n
);

	logic [7:0] los_flags;
	logic [7:0] fault_flags;
	logic [7:0] lock_flags;
	logic [7:0] los_cond;
	logic [7:0] fault_cond;
	logic [7:0] lock_cond;
	logic [7:0] los_supported;
	logic [7:0] fault_supported;
	logic [7:0] status_byte;
	logic [7:0] rd_mux;
	logic       hit_los;
	logic       hit_fault;
	logic       hit_lock;
	logic       hit_rev;
	logic       hit_status;
	logic       pin_clear;
	logic       any_flag;
	logic       int_n_reg;
	logic       not_ready_reg;
	logic       rd_valid_reg;
	logic [7:0] rd_data_reg;

	// the serial engine hands one strobe per byte, so each location decodes alone
	assign hit_rev    = rd_req.strobe && (rd_req.addr == msf_pkg::OFF_REVISION);
	assign hit_status = rd_req.strobe && (rd_req.addr == msf_pkg::OFF_STATUS);
	assign hit_los    = rd_req.strobe && (rd_req.addr == msf_pkg::OFF_LOS_FLAGS);
	assign hit_fault  = rd_req.strobe && (rd_req.addr == msf_pkg::OFF_FAULT);
	assign hit_lock   = rd_req.strobe && (rd_req.addr == msf_pkg::OFF_LOCK_LOSS);
	assign pin_clear  = ~module_reset_n;

	// tx signal loss is not detected in this module, those bits are tied off
	assign los_cond      = {4'h0, cond.rx_los};
	assign los_supported = {4'h0, 4'hf};
	assign fault_cond    = {cond.tx_eq_fault, cond.tx_laser_fault};
	assign fault_supported = {{4{EQ_SUPPORTED}}, 4'hf};
	assign lock_cond     = {cond.tx_unlock, cond.rx_unlock};

	msf_flag_latch #(
		.WIDTH (8)
	) u_los (
		.clk        (clk),
		.reset      (reset),
		.cond       (los_cond),
		.supported  (los_supported),
		.read_clear (hit_los),
		.pin_clear  (pin_clear),
		.flags      (los_flags)
	);

	msf_flag_latch #(
		.WIDTH (8)
	) u_fault (
		.clk        (clk),
		.reset      (reset),
		.cond       (fault_cond),
		.supported  (fault_supported),
		.read_clear (hit_fault),
		.pin_clear  (pin_clear),
		.flags      (fault_flags)
	);

	msf_flag_latch #(
		.WIDTH (8)
	) u_lock (
		.clk        (clk),
		.reset      (reset),
		.cond       (lock_cond),
		.supported  (8'hff),
		.read_clear (hit_lock),
		.pin_clear  (pin_clear),
		.flags      (lock_flags)
	);

	// masks live outside this block, so any latched flag pulls the pin; host then reads flags
	assign any_flag = |{los_flags, fault_flags, lock_flags};

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			int_n_reg <= 1'b1;
		else
			int_n_reg <= ~any_flag;
	end

	assign interrupt_out_n = int_n_reg;

	// sticky once low: monitors do not become unready again without a full reset
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			not_ready_reg <= 1'b1;
		else if (monitor_ready)
			not_ready_reg <= 1'b0;
	end

	always_comb
	begin
		status_byte = 8'h00;
		status_byte[msf_pkg::STS_FLAT_MEM_BIT]  = FLAT_MEM;
		status_byte[msf_pkg::STS_INT_PIN_BIT]   = int_n_reg;
		status_byte[msf_pkg::STS_NOT_READY_BIT] = not_ready_reg;
	end

	// value returned is the pre-clear content, so the read sees what it clears
	assign rd_mux = hit_rev    ? REVISION_CODE :
	                hit_status ? status_byte :
	                hit_los    ? los_flags :
	                hit_fault  ? fault_flags :
	                hit_lock   ? lock_flags :
	                msf_pkg::UNMAPPED_DATA;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rd_valid_reg <= 1'b0;
			rd_data_reg  <= msf_pkg::RD_DATA_RESET;
		end
		else
		begin
			rd_valid_reg <= rd_req.strobe;
			if (rd_req.strobe)
				rd_data_reg <= rd_mux;
		end
	end

	assign rd_rsp.valid = rd_valid_reg;
	assign rd_rsp.data  = rd_data_reg;

endmodule // msf_status_flags

/* File: tb/msf_host_model.sv */
// host side model: single byte reads toward the flag block
`timescale 1ns/1ps
module msf_host_model (
	input  wire logic            clk,
	input  wire logic            go,
	input  wire logic [7:0]      addr,
	output msf_pkg::msf_rd_req_s rd_req
);
	// idle address keeps moving so a stale value never reads as valid
	always_ff @(posedge clk)
		rd_req <= go ? {1'b1, addr} : {1'b0, ~rd_req.addr};
endmodule // msf_host_model

/* File: tb/msf_status_flags_properties.sv */
// checker: port timing of the status and flag bytes
`timescale 1ns/1ps
module msf_chk (
	input wire logic                 clk,
	input wire logic                 reset,
	input wire logic                 module_reset_n,
	input wire logic                 monitor_ready,
	input wire msf_pkg::msf_cond_s   cond,
	input wire msf_pkg::msf_rd_req_s rd_req,
	input wire msf_pkg::msf_rd_rsp_s rd_rsp,
	input wire logic                 interrupt_out_n
);
	wire rd2 = rd_req.strobe && rd_req.addr == 8'h02;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	rsp_timing_a: assert property (rd_rsp.valid == $past(rd_req.strobe)) else $error("valid late");
	rev_code_a: assert property (rd_req.strobe && rd_req.addr == 8'h01 |=> rd_rsp.data == 8'h07)
		else $error("bad revision");
	status_top_a: assert property (rd2 |=> rd_rsp.data[7:2] == 6'h00) else $error("bad status");
	pin_mirror_a: assert property (rd2 |=> rd_rsp.data[1] == $past(interrupt_out_n)) else $error("pin");
	ready_low_a: assert property ($past(monitor_ready) && rd2 |=> !rd_rsp.data[0]) else $error("ready");
	int_set_a: assert property (|cond && module_reset_n |-> ##2 !interrupt_out_n) else $error("no irq");
	pin_clear_a: assert property (!module_reset_n |-> ##2 interrupt_out_n) else $error("no clear");
	flag_hold_a: assert property (!$past(rd_req.strobe) && $past(module_reset_n) && !interrupt_out_n
		|=> !interrupt_out_n) else $error("flag lost");
endmodule // msf_chk

bind msf_status_flags msf_chk i_msf_chk (.clk, .reset, .module_reset_n, .monitor_ready, .cond, .rd_req, .rd_rsp,
	.interrupt_out_n);

/* File: tb/tb_msf_status_flags.sv */
// testbench: reads status and flag bytes through the host model
`timescale 1ns/1ps
module tb_msf_status_flags;
	logic                 clk = 1'b0;
	logic                 reset = 1'b1;
	logic                 module_reset_n = 1'b1;
	logic                 monitor_ready = 1'b0;
	logic                 go = 1'b0;
	logic [7:0]           addr = 8'h00;
	msf_pkg::msf_cond_s   cond = '0;
	msf_pkg::msf_rd_req_s rd_req;
	msf_pkg::msf_rd_rsp_s rd_rsp;
	logic                 interrupt_out_n;
	int                   error_cnt = 0;
	int                   total_checks = 0;
	always #25 clk = ~clk;
	msf_host_model i_msf_host_model (.clk, .go, .addr, .rd_req);
	msf_status_flags i_msf_status_flags (.clk, .reset, .module_reset_n, .monitor_ready, .cond, .rd_req, .rd_rsp,
		.interrupt_out_n);
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// the pin is a registered level, so mid-cycle sampling sees it settled
	task automatic chk_pin(input logic e);
		@(negedge clk);
		total_checks++;
		if (interrupt_out_n !== e)
		begin
			error_cnt++;
			$display("ERROR interrupt_out_n expected %b seen %b", e, interrupt_out_n);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		go <= 1'b1;
		addr <= a;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		total_checks++;
		if (rd_rsp.data !== e)
		begin
			error_cnt++;
			$display("ERROR byte %h expected %h seen %h", a, e, rd_rsp.data);
		end
	endtask
	initial
	begin
		#100000;
		error_cnt++;
		end_of_test();
	end
	initial
	begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		rd(8'h01, 8'h07);
		rd(8'h02, 8'h03);
		rd(8'h03, 8'h00);
		@(posedge clk);
		monitor_ready <= 1'b1;
		rd(8'h02, 8'h02);
		@(posedge clk);
		cond <= {4'h1, 4'h2, 4'h4, 4'h8, 4'h3};
		@(posedge clk);
		cond <= '0;
		rd(8'h02, 8'h00);
		chk_pin(1'b0);
		rd(8'h03, 8'h01);
		rd(8'h03, 8'h00);
		rd(8'h04, 8'h24);
		rd(8'h05, 8'h83);
		rd(8'h02, 8'h02);
		@(posedge clk);
		cond.rx_los <= 4'h8;
		rd(8'h03, 8'h08);
		@(posedge clk);
		cond <= '0;
		rd(8'h03, 8'h08);
		@(posedge clk);
		cond.tx_laser_fault <= 4'hf;
		@(posedge clk);
		cond <= '0;
		module_reset_n <= 1'b0;
		@(posedge clk);
		module_reset_n <= 1'b1;
		rd(8'h04, 8'h00);
		rd(8'h02, 8'h02);
		chk_pin(1'b1);
		end_of_test();
	end
endmodule // tb_msf_status_flags
